// >>> src/ctx_pkg.sv
// Purpose: Shared constants and types for the transfer and RAM-address execution block.
// Assumes: One 10-bit instruction word is presented per cycle with a valid strobe.
// Notes: Opcodes are the 10-bit instruction codes of the handled instructions.
`default_nettype none
package ctx_pkg;
    localparam logic [9:0] OP_COPY_B_TO_ACC = 10'h01e;
    localparam logic [9:0] OP_COPY_ACC_TO_B = 10'h00e;
    localparam logic [9:0] OP_COPY_Y_TO_ACC = 10'h01f;
    localparam logic [9:0] OP_COPY_ACC_TO_Y = 10'h00c;
    localparam logic [9:0] OP_LOAD_E_PAIR = 10'h01a;
    localparam logic [9:0] OP_READ_E_PAIR = 10'h02a;
    localparam logic [9:0] OP_LOAD_ROM_PAGE_PTR = 10'h029;
    localparam logic [9:0] OP_READ_ROM_PAGE_PTR = 10'h051;
    localparam logic [9:0] OP_READ_BANK_SELECT = 10'h053;
    localparam logic [9:0] OP_COPY_X_TO_ACC = 10'h052;
    localparam logic [9:0] OP_READ_STACK_PTR = 10'h050;
    localparam logic [9:0] OP_INCREMENT_Y_SKIP = 10'h013;
    localparam logic [9:0] OP_DECREMENT_Y_SKIP = 10'h017;
    localparam logic [9:0] OP_WATCHDOG_FLAG_TEST_CLEAR = 10'h2a0;
    localparam logic [9:0] OP_WRITE_TIMER_CTRL_TWO = 10'h20f;
    localparam logic [9:0] OP_WRITE_TIMER_CTRL_THREE = 10'h210;
    localparam logic [9:0] OP_WRITE_TIMER_CTRL_FOUR = 10'h211;
    // Upper-bit patterns of instructions carrying an immediate field.
    localparam logic [1:0] PF_LOAD_X_Y_IMMEDIATE = 2'h3;
    localparam logic [7:0] PF_LOAD_BANK_IMMEDIATE = 8'h12;
    localparam logic [5:0] PF_LOAD_ACC_FROM_MEM = 6'h2c;
    localparam logic [5:0] PF_SWAP_ACC_MEM = 6'h2d;
    localparam logic [5:0] PF_SWAP_ACC_MEM_DEC = 6'h2f;
    localparam logic [5:0] PF_SWAP_ACC_MEM_INC = 6'h2e;
    localparam logic [5:0] PF_STORE_ACC_TO_MEM = 6'h2b;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [3:0] Y_WRAP_UP = 4'h0;
    localparam logic [3:0] Y_WRAP_DN = 4'hf;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] b;
        logic [3:0] x;
        logic [3:0] y;
        logic [1:0] z;
        logic [2:0] d;
        logic [7:0] e;
    } ctx_regs_t;

    typedef struct packed {
        logic we;
        logic [3:0] data;
    } ctx_mem_wr_t;

    typedef struct packed {
        logic [3:0] w2;
        logic [3:0] w3;
        logic [3:0] w4;
    } ctx_timer_ctrl_t;
endpackage
`default_nettype wire

// >>> src/ctx_exec.sv
// Purpose: Executes register-transfer, RAM-address, RAM-to-register and watchdog-flag instructions.
// Assumes: RAM data at the data pointer is presented combinationally; stack pointer comes from outside.
// Notes: A skipped instruction changes no register or RAM; it clears the skip state and still updates the X-Y load chain.
// Behaviour
// RL1: Copy between accumulator and B both ways.
// RL2: Copy between accumulator and Y both ways.
// RL3: Load E from B high, accumulator low.
// RL4: Read E into B and accumulator.
// RL5: Load D from accumulator low three bits.
// RL6: Read D into accumulator, top bit zero.
// RL7: Read Z into accumulator, upper bits zero.
// RL8: Copy X into accumulator.
// RL9: Read stack pointer into accumulator, top zero.
// RL10: Load X and Y; repeated loads skipped.
// RL11: Load Z from two-bit immediate.
// RL12: Increment Y, skip when zero.
// RL13: Decrement Y, skip when fifteen.
// RL14: Load accumulator from RAM, X xor j.
// RL15: Swap accumulator with RAM, X xor j.
// RL16: Swap, X xor j, decrement Y, skip.
// RL17: Swap, X xor j, increment Y, skip.
// RL18: Store accumulator to RAM, X xor j.
// RL19: Test, clear watchdog flag; skip if set.
// RL20: Write accumulator into timer control registers.
// RL21: Skipped instruction changes no register or RAM; it still updates the X-Y load chain.
`default_nettype none
module ctx_exec (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Instruction stream
    input wire logic instr_valid_in,
    input wire logic [9:0] instr_in,
    // Data inputs
    input wire logic [3:0] mem_rdata_in,
    input wire logic [2:0] stack_ptr_in,
    input wire logic wdt_flag_set_in,
    // Register and control outputs
    output ctx_pkg::ctx_regs_t regs_out,
    output ctx_pkg::ctx_mem_wr_t mem_wr_out,
    output ctx_pkg::ctx_timer_ctrl_t timer_ctrl_out,
    output logic skip_out,
    output logic wdt_flag_out
);
    import ctx_pkg::*;

    // Architectural registers, the pending write, and the skip and chain state.
    ctx_regs_t r_q, r_d;
    ctx_mem_wr_t mw_q, mw_d;
    ctx_timer_ctrl_t tc_q, tc_d;
    logic skip_q, skip_d;
    logic xy_run_q, xy_run_d;
    logic wdf_q, wdf_d;

    // Skip decision after a Y step: wrap to zero going up, to fifteen going down.
    function automatic logic y_wrap_skip(input logic [3:0] y_new, input logic up);
        if (up) begin
            return y_new == Y_WRAP_UP;
        end
        return y_new == Y_WRAP_DN;
    endfunction

    // Instruction fields and the execute qualifier.
    wire logic [9:0] op = instr_in;
    wire logic [3:0] imm = op[3:0];
    wire logic [3:0] x_imm = op[7:4];
    wire logic [1:0] z_imm = op[1:0];
    wire logic live = instr_valid_in && !skip_q; // see RL21

    // Single-code instructions.
    wire logic dec_b_to_acc = (op == OP_COPY_B_TO_ACC);
    wire logic dec_acc_to_b = (op == OP_COPY_ACC_TO_B);
    wire logic dec_y_to_acc = (op == OP_COPY_Y_TO_ACC);
    wire logic dec_acc_to_y = (op == OP_COPY_ACC_TO_Y);
    wire logic dec_load_e = (op == OP_LOAD_E_PAIR);
    wire logic dec_read_e = (op == OP_READ_E_PAIR);
    wire logic dec_load_d = (op == OP_LOAD_ROM_PAGE_PTR);
    wire logic dec_read_d = (op == OP_READ_ROM_PAGE_PTR);
    wire logic dec_read_z = (op == OP_READ_BANK_SELECT);
    wire logic dec_x_to_acc = (op == OP_COPY_X_TO_ACC);
    wire logic dec_read_sp = (op == OP_READ_STACK_PTR);
    wire logic dec_inc_y = (op == OP_INCREMENT_Y_SKIP);
    wire logic dec_dec_y = (op == OP_DECREMENT_Y_SKIP);
    wire logic dec_wdt = (op == OP_WATCHDOG_FLAG_TEST_CLEAR);
    wire logic dec_tw2 = (op == OP_WRITE_TIMER_CTRL_TWO);
    wire logic dec_tw3 = (op == OP_WRITE_TIMER_CTRL_THREE);
    wire logic dec_tw4 = (op == OP_WRITE_TIMER_CTRL_FOUR);

    // Instruction groups that carry an immediate field.
    wire logic is_xy_load = (op[9:8] == PF_LOAD_X_Y_IMMEDIATE);
    wire logic is_bank_load = (op[9:2] == PF_LOAD_BANK_IMMEDIATE);
    wire logic is_mem_load = (op[9:4] == PF_LOAD_ACC_FROM_MEM);
    wire logic is_swap_plain = (op[9:4] == PF_SWAP_ACC_MEM);
    wire logic is_swap_dec = (op[9:4] == PF_SWAP_ACC_MEM_DEC);
    wire logic is_swap_inc = (op[9:4] == PF_SWAP_ACC_MEM_INC);
    wire logic is_mem_store = (op[9:4] == PF_STORE_ACC_TO_MEM);
    wire logic is_swap = is_swap_plain || is_swap_dec || is_swap_inc;
    wire logic x_upd = is_mem_load || is_swap || is_mem_store;

    // Y steps wrap modulo sixteen; a repeated X-Y load is suppressed.
    wire logic [3:0] y_inc = r_q.y + 4'h1;
    wire logic [3:0] y_dec = r_q.y - 4'h1;
    wire logic xy_repeat = is_xy_load && xy_run_q; // see RL10

    always_comb begin
        r_d = r_q;
        mw_d = '{we: 1'b0, data: r_q.acc};
        tc_d = tc_q;
        skip_d = 1'b0;
        xy_run_d = xy_run_q;
        wdf_d = wdf_q || wdt_flag_set_in;
        // Any accepted slot other than an X-Y load breaks the load chain.
        if (instr_valid_in) begin
            xy_run_d = is_xy_load;
        end
        if (live && !xy_repeat) begin
            case (op)
                OP_COPY_B_TO_ACC: begin
                    r_d.acc = r_q.b; // see RL1
                end
                OP_COPY_ACC_TO_B: begin
                    r_d.b = r_q.acc; // see RL1
                end
                OP_COPY_Y_TO_ACC: begin
                    r_d.acc = r_q.y; // see RL2
                end
                OP_COPY_ACC_TO_Y: begin
                    r_d.y = r_q.acc; // see RL2
                end
                OP_LOAD_E_PAIR: begin
                    r_d.e = {r_q.b, r_q.acc}; // see RL3
                end
                OP_READ_E_PAIR: begin
                    r_d.b = r_q.e[7:4]; // see RL4
                    r_d.acc = r_q.e[3:0];
                end
                OP_LOAD_ROM_PAGE_PTR: begin
                    r_d.d = r_q.acc[2:0]; // see RL5
                end
                OP_READ_ROM_PAGE_PTR: begin
                    r_d.acc = {1'b0, r_q.d}; // see RL6
                end
                OP_READ_BANK_SELECT: begin
                    r_d.acc = {2'b00, r_q.z}; // see RL7
                end
                OP_COPY_X_TO_ACC: begin
                    r_d.acc = r_q.x; // see RL8
                end
                OP_READ_STACK_PTR: begin
                    r_d.acc = {1'b0, stack_ptr_in}; // see RL9
                end
                OP_INCREMENT_Y_SKIP: begin
                    r_d.y = y_inc; // see RL12
                    skip_d = y_wrap_skip(y_inc, 1'b1);
                end
                OP_DECREMENT_Y_SKIP: begin
                    r_d.y = y_dec; // see RL13
                    skip_d = y_wrap_skip(y_dec, 1'b0);
                end
                OP_WATCHDOG_FLAG_TEST_CLEAR: begin
                    skip_d = wdf_q; // see RL19
                    wdf_d = wdt_flag_set_in;
                end
                OP_WRITE_TIMER_CTRL_TWO: begin
                    tc_d.w2 = r_q.acc; // see RL20
                end
                OP_WRITE_TIMER_CTRL_THREE: begin
                    tc_d.w3 = r_q.acc; // see RL20
                end
                OP_WRITE_TIMER_CTRL_FOUR: begin
                    tc_d.w4 = r_q.acc; // see RL20
                end
                default: begin
                    if (is_xy_load) begin
                        r_d.x = x_imm; // see RL10
                        r_d.y = imm;
                    end
                    if (is_bank_load) begin
                        r_d.z = z_imm; // see RL11
                    end
                    if (is_mem_load || is_swap) begin
                        r_d.acc = mem_rdata_in; // see RL14
                    end
                    if (is_swap || is_mem_store) begin
                        mw_d.we = 1'b1; // see RL15
                    end
                    if (x_upd) begin
                        r_d.x = r_q.x ^ imm; // see RL18
                    end
                    if (is_swap_dec) begin
                        r_d.y = y_dec; // see RL16
                        skip_d = y_wrap_skip(y_dec, 1'b0);
                    end
                    if (is_swap_inc) begin
                        r_d.y = y_inc; // see RL17
                        skip_d = y_wrap_skip(y_inc, 1'b1);
                    end
                end
            endcase
        end
        // A pending skip is consumed by the next valid slot and held across gaps.
        if (instr_valid_in && skip_q) begin
            skip_d = 1'b0;
        end else if (!instr_valid_in) begin
            skip_d = skip_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            r_q <= '0;
            mw_q <= '0;
            tc_q <= '0;
            skip_q <= 1'b0;
            xy_run_q <= 1'b0;
            wdf_q <= 1'b0;
        end else begin
            r_q <= r_d;
            mw_q <= mw_d;
            tc_q <= tc_d;
            skip_q <= skip_d;
            xy_run_q <= xy_run_d;
            wdf_q <= wdf_d;
        end
    end

    assign regs_out = r_q;
    assign mem_wr_out = mw_q;
    assign timer_ctrl_out = tc_q;
    assign skip_out = skip_q;
    assign wdt_flag_out = wdf_q;

    // Each check looks one cycle after the instruction slot it covers, whether executed, skipped or a suppressed repeat load.
    acc_from_b_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL1
        live && dec_b_to_acc |=> r_q.acc == $past(r_q.b))
        else $error("acc not loaded from b");
    b_from_acc_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL1
        live && dec_acc_to_b |=> r_q.b == $past(r_q.acc))
        else $error("b not loaded from acc");
    y_copy_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL2
        live && dec_acc_to_y |=> r_q.y == $past(r_q.acc) && !skip_q)
        else $error("y not loaded from acc");
    e_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL3
        live && dec_load_e |=> r_q.e == {$past(r_q.b), $past(r_q.acc)})
        else $error("e pair wrong");
    e_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL4
        live && dec_read_e |=> {r_q.b, r_q.acc} == $past(r_q.e))
        else $error("e pair read wrong");
    d_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL5
        live && dec_load_d |=> r_q.d == $past(r_q.acc[2:0]))
        else $error("d load wrong");
    d_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL6
        live && dec_read_d |=> r_q.acc[3] == 1'b0 && r_q.acc[2:0] == $past(r_q.d))
        else $error("d read wrong");
    z_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL7
        live && dec_read_z |=> r_q.acc == {2'b00, $past(r_q.z)})
        else $error("z read wrong");
    x_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL8
        live && dec_x_to_acc |=> r_q.acc == $past(r_q.x) && r_q.x == $past(r_q.x))
        else $error("x read wrong");
    sp_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL9
        live && dec_read_sp |=> r_q.acc == {1'b0, $past(stack_ptr_in)})
        else $error("stack pointer read wrong");
    y_up_skip_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL12
        live && dec_inc_y |=> r_q.y == $past(r_q.y) + 4'h1 && skip_q == (r_q.y == 4'h0))
        else $error("y increment skip wrong");
    y_down_skip_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL13
        live && dec_dec_y |=> r_q.y == $past(r_q.y) - 4'h1 && skip_q == (r_q.y == 4'hf))
        else $error("y decrement skip wrong");
    xy_repeat_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL10
        instr_valid_in && is_xy_load ##1 instr_valid_in && is_xy_load && !skip_q |=> r_q.x == $past(r_q.x, 1))
        else $error("repeated xy load executed");
    z_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL11
        live && is_bank_load |=> r_q.z == $past(z_imm))
        else $error("z load wrong");
    mem_store_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL18
        live && is_mem_store |=> mw_q.we && mw_q.data == $past(r_q.acc) && r_q.x == ($past(r_q.x) ^ $past(imm)))
        else $error("store missing");
    xor_x_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL14
        live && is_mem_load |=> r_q.x == ($past(r_q.x) ^ $past(imm)) && r_q.acc == $past(mem_rdata_in))
        else $error("x xor wrong");
    swap_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL15
        live && is_swap |=> mw_q.we && mw_q.data == $past(r_q.acc) && r_q.acc == $past(mem_rdata_in))
        else $error("swap wrong");
    swap_down_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL16
        live && is_swap_dec |=> r_q.y == $past(r_q.y) - 4'h1 && skip_q == (r_q.y == 4'hf))
        else $error("swap decrement wrong");
    swap_up_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL17
        live && is_swap_inc |=> r_q.y == $past(r_q.y) + 4'h1 && skip_q == (r_q.y == 4'h0))
        else $error("swap increment wrong");
    wdt_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL19
        live && dec_wdt && !wdt_flag_set_in |=> !wdf_q && skip_q == $past(wdf_q))
        else $error("wdt test wrong");
    timer_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL20
        live && dec_tw2 |=> tc_q.w2 == $past(r_q.acc))
        else $error("timer control write wrong");
    skip_nop_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // see RL21
        instr_valid_in && skip_q |=> r_q == $past(r_q) && !mw_q.we && !skip_q)
        else $error("skipped instr acted");

    // Main scenarios worth seeing at least once.
    y_wrap_c: cover property (@(posedge ref_clk_in) live && dec_inc_y && r_q.y == 4'hf);
    swap_dec_c: cover property (@(posedge ref_clk_in) live && is_swap_dec);
    wdt_skip_c: cover property (@(posedge ref_clk_in) live && dec_wdt && wdf_q);
    xy_pair_c: cover property (@(posedge ref_clk_in) instr_valid_in && is_xy_load ##1 instr_valid_in && is_xy_load);
    timer_c: cover property (@(posedge ref_clk_in) live && (dec_tw3 || dec_tw4));
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the transfer and RAM-address execution block.
// Assumes: One instruction per clock; outputs update one edge after the instruction is taken.
// Notes: A reference model runs at each rising edge and outputs are compared at the falling edge, write data only when a write is expected.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ctx_pkg::*;
    logic ref_clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic instr_valid_in = 1'h0;
    logic [9:0] instr_in = 10'h000;
    logic [3:0] mem_rdata_in = 4'h0;
    logic [2:0] stack_ptr_in = 3'h0;
    logic wdt_flag_set_in = 1'h0;
    ctx_regs_t regs_out, m;
    ctx_mem_wr_t mem_wr_out;
    ctx_timer_ctrl_t timer_ctrl_out, mt;
    logic skip_out, wdt_flag_out, ms, mw, mc, mwe, armed = 1'h0, may_skip = 1'h0;
    logic [3:0] mwd;
    logic [31:0] seed = 32'h0000005a;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    // Bit 10 raises the watchdog set input alongside the instruction.
    logic [10:0] corner [33] = '{11'h3ff, 11'h3a5, 11'h3c3, 11'h013, 11'h01e, 11'h017, 11'h052, 11'h2ff,
        11'h2d5, 11'h2b3, 11'h2c9, 11'h2e1, 11'h00e, 11'h01a, 11'h02a, 11'h029, 11'h051, 11'h053,
        11'h050, 11'h01f, 11'h00c, 11'h04b, 11'h20f, 11'h210, 11'h211, 11'h400, 11'h2a0, 11'h01e,
        11'h2a0, 11'h6a0, 11'h2a0, 11'h3f0, 11'h2e0};

    ctx_exec dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .mem_rdata_in(mem_rdata_in), .stack_ptr_in(stack_ptr_in),
        .wdt_flag_set_in(wdt_flag_set_in), .regs_out(regs_out), .mem_wr_out(mem_wr_out),
        .timer_ctrl_out(timer_ctrl_out), .skip_out(skip_out), .wdt_flag_out(wdt_flag_out));

    always #4 ref_clk_in = ~ref_clk_in;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic skipper(input logic [9:0] c);
        return c == 10'h013 || c == 10'h017 || c == 10'h2a0 || c[9:5] == 5'h17;
    endfunction

    task automatic step();
        logic [9:0] c;
        logic [3:0] a;
        logic wc;
        c = instr_in;
        a = m.acc;
        wc = 1'h0;
        mwe = 1'h0;
        if (instr_valid_in && ms) begin
            ms = 1'h0;
            mc = 1'h0;
        end else if (instr_valid_in) begin
            if (c[9:8] == 2'h3 && !mc) begin
                m.x = c[7:4];
                m.y = c[3:0];
            end
            mc = c[9:8] == 2'h3;
            case (c)
                10'h01e: m.acc = m.b;
                10'h00e: m.b = a;
                10'h01f: m.acc = m.y;
                10'h00c: m.y = a;
                10'h01a: m.e = {m.b, a};
                10'h02a: {m.b, m.acc} = m.e;
                10'h029: m.d = a[2:0];
                10'h051: m.acc = {1'h0, m.d};
                10'h053: m.acc = {2'h0, m.z};
                10'h052: m.acc = m.x;
                10'h050: m.acc = {1'h0, stack_ptr_in};
                10'h013, 10'h017: m.y = c[2] ? m.y - 4'h1 : m.y + 4'h1;
                10'h2a0: begin ms = mw; wc = 1'h1; end
                10'h20f: mt.w2 = a;
                10'h210: mt.w3 = a;
                10'h211: mt.w4 = a;
                default: ;
            endcase
            if (c[9:4] == 6'h2c) m.acc = mem_rdata_in;
            if (c[9:4] == 6'h2b || c[9:5] == 5'h17 || c[9:4] == 6'h2d) begin
                mwe = 1'h1;
                mwd = a;
                if (c[9:4] != 6'h2b) m.acc = mem_rdata_in;
            end
            if (c[9:6] == 4'hb || c[9:4] == 6'h2b) m.x = m.x ^ c[3:0];
            if (c[9:4] == 6'h2e) m.y = m.y + 4'h1;
            if (c[9:4] == 6'h2f) m.y = m.y - 4'h1;
            if (c == 10'h013 || c[9:4] == 6'h2e) ms = m.y == 4'h0;
            if (c == 10'h017 || c[9:4] == 6'h2f) ms = m.y == 4'hf;
            if (c[9:2] == 8'h12) m.z = c[1:0];
        end
        mw = (wc ? 1'h0 : mw) | wdt_flag_set_in;
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (reset_in) begin
            m = '0; mt = '0; ms = 1'h0; mw = 1'h0; mc = 1'h0; mwe = 1'h0; mwd = 4'h0;
        end else step();
        armed = 1'h1;
        if (cyc == 12000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    always @(negedge ref_clk_in) begin
        if (armed) begin
            chk("regs", 32'(m), 32'(regs_out));
            chk("timer", 32'(mt), 32'(timer_ctrl_out));
            chk("skip", 32'(ms), 32'(skip_out));
            chk("wdt", 32'(mw), 32'(wdt_flag_out));
            chk("mem_we", 32'(mwe), 32'(mem_wr_out.we));
            if (mwe) chk("mem_data", 32'(mwd), 32'(mem_wr_out.data));
        end
    end

    task automatic drive(input logic [9:0] c, input logic v, input logic s);
        logic [31:0] r;
        r = xs();
        @(posedge ref_clk_in);
        // A skipped load-XY has no defined effect on the repeat chain, so it is kept out.
        if (v && may_skip && c[9:8] == 2'h3) c = 10'h01e;
        if (v) may_skip = skipper(c);
        instr_in <= c;
        instr_valid_in <= v;
        wdt_flag_set_in <= s;
        mem_rdata_in <= r[3:0];
        stack_ptr_in <= r[6:4];
    endtask

    task automatic rand_run(input int n);
        logic [31:0] r;
        repeat (n) begin
            r = xs();
            drive(r[20] ? corner[r[27:21] % 33][9:0] : r[9:0], r[12:11] != 2'h0, r[15:13] == 3'h0);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'h0;
        foreach (corner[i]) drive(corner[i][9:0], 1'h1, corner[i][10]);
        drive(10'h013, 1'h1, 1'h0);
        drive(10'h01e, 1'h0, 1'h0);
        drive(10'h00e, 1'h1, 1'h0);
        $display("corner test done");
        rand_run(3000);
        $display("random test done");
        @(posedge ref_clk_in);
        reset_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'h0;
        rand_run(200);
        $display("reset test done");
        drive(10'h000, 1'h0, 1'h0);
        @(posedge ref_clk_in);
        tally_and_finish();
    end
endmodule
`default_nettype wire
